// [common/cpl_consts.vh]
// constants for the color palette lookup block
// Overview of operation
// (R1) target select 00/10 address register, 01 palette ram, 11 overlay colors
// (R2) writing the address register loads the index and clears color phase
// (R3) color phase counts modulo three: red, green, blue
// (R4) reading the address register keeps the phase; phase is never host visible
// (R5) red and green bytes held; blue write stores 24-bit word, index increments
// (R6) three reads return red, green, blue; index increments after blue
// (R7) blue access at palette location ff wraps the index to 00
// (R8) overlay access uses only the two low index bits; 00 is reserved
// (R9) blue overlay access also increments the index
// (R10) host select low forces all video outputs to black
// (R11) select high: overlay 00 uses palette by pixel index, else overlay color
// (R12) sync and blank captured with pixel data; blank gives blank, sync gives sync
// (R13) host port needs no timing relation to the pixel path
// (R14) color, sync and blank effects reach outputs two cycles after capture
// (R15) host holds select low with one strobe through the whole access
// (R16) write data captured on first rising edge of write strobe or select
// (R17) host never drives select, read and write low together
`ifndef CPL_CONSTS_VH
`define CPL_CONSTS_VH
`define CPL_TGT_ADDR_A 2'h0
`define CPL_TGT_PAL 2'h1
`define CPL_TGT_ADDR_B 2'h2
`define CPL_TGT_OVL 2'h3
`define CPL_PH_RED 2'h0
`define CPL_PH_GRN 2'h1
`define CPL_PH_BLU 2'h2
`define CPL_IDX_LAST 8'hff
`define CPL_IDX_FIRST 8'h00
`define CPL_OVL_RSVD 2'h0
`define CPL_PIPE_DEPTH 2
`define CPL_BLACK 8'h00
`endif

// [rtl/cpl_overlay_bank.v]
// three overlay color registers with write port and two read ports
`timescale 1ns/10ps
`include "cpl_consts.vh"
module cpl_overlay_bank (
  input wire clk_sys,
  input wire sys_rst,
  input wire wr_en,
  input wire [1:0] wr_sel,
  input wire [23:0] wr_data,
  input wire [1:0] rd_sel_a,
  output wire [23:0] rd_data_a,
  input wire [1:0] rd_sel_b,
  output wire [23:0] rd_data_b
);
  reg [23:0] ovl_reg [0:3];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ovl
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          ovl_reg[gi] <= 24'h000000;
        end else if (wr_en && wr_sel == gi && gi != 0) begin // (R8)
          ovl_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate
  assign rd_data_a = ovl_reg[rd_sel_a];
  assign rd_data_b = ovl_reg[rd_sel_b];
endmodule // cpl_overlay_bank

// [rtl/cpl_palette_lookup.v]
// color palette lookup: host port, palette ram, pixel pipeline
`timescale 1ns/10ps
`include "cpl_consts.vh"
module cpl_palette_lookup (
  input wire clk_sys,
  input wire sys_rst,
  input wire host_select_n,
  input wire host_read_n,
  input wire host_write_n,
  input wire target_select_lo,
  input wire target_select_hi,
  input wire [7:0] host_data_in,
  output wire [7:0] host_data_out,
  output wire host_data_oe_n,
  input wire [7:0] pixel_index,
  input wire overlay_select_lo,
  input wire overlay_select_hi,
  input wire sync_n,
  input wire blank_n,
  output wire [7:0] red_video_out,
  output wire [7:0] green_video_out,
  output wire [7:0] blue_video_out,
  output wire video_sync_n,
  output wire video_blank_n
);
  wire [1:0] tgt = {target_select_hi, target_select_lo};
  wire sel_addr = (tgt == `CPL_TGT_ADDR_A) || (tgt == `CPL_TGT_ADDR_B); // (R1)
  wire sel_pal = (tgt == `CPL_TGT_PAL); // (R1)
  wire sel_ovl = (tgt == `CPL_TGT_OVL); // (R1)
  // strobes sampled synchronously; access acts once, at its end
  wire wr_act = !host_select_n && !host_write_n && host_read_n; // (R15) (R17)
  wire rd_act = !host_select_n && !host_read_n && host_write_n; // (R15) (R17)
  reg wr_act_reg;
  reg rd_act_reg;
  reg [7:0] wr_data_reg;
  reg [7:0] palette_index_reg;
  reg [7:0] palette_index_next;
  reg [1:0] phase_reg;
  reg [1:0] phase_next;
  reg [7:0] red_hold_reg;
  reg [7:0] grn_hold_reg;
  reg [7:0] rd_data_reg;
  reg [23:0] pal_mem [0:255];
  wire wr_end = wr_act_reg && !wr_act; // (R16)
  wire rd_end = rd_act_reg && !rd_act;
  wire [23:0] host_pal_word = pal_mem[palette_index_reg];
  wire [23:0] host_ovl_word;
  wire [23:0] host_word = sel_ovl ? host_ovl_word : host_pal_word;
  wire color_acc = sel_pal || sel_ovl;
  wire blue_phase = (phase_reg == `CPL_PH_BLU);
  wire pal_store = wr_end && sel_pal && blue_phase; // (R5)
  wire ovl_store = wr_end && sel_ovl && blue_phase; // (R5)
  wire [23:0] store_word = {red_hold_reg, grn_hold_reg, wr_data_reg};

  // capture data while the write is open, so the last value before release is kept
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_act_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_act_reg <= wr_act;
      rd_act_reg <= rd_act;
      if (wr_act) begin
        wr_data_reg <= host_data_in; // (R16)
      end
    end
  end

  always @* begin
    palette_index_next = palette_index_reg;
    phase_next = phase_reg;
    if (wr_end && sel_addr) begin
      palette_index_next = wr_data_reg; // (R2)
      phase_next = `CPL_PH_RED; // (R2)
    end else if ((wr_end || rd_end) && color_acc) begin
      if (blue_phase) begin
        phase_next = `CPL_PH_RED; // (R3)
        // natural 8-bit rollover gives ff to 00
        palette_index_next = palette_index_reg + 8'h01; // (R6) (R7) (R9)
      end else begin
        phase_next = phase_reg + 2'h1; // (R3)
      end
    end
    // address register read leaves phase alone
  end // (R4)

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      palette_index_reg <= 8'h00;
      phase_reg <= `CPL_PH_RED;
      red_hold_reg <= 8'h00;
      grn_hold_reg <= 8'h00;
    end else begin
      palette_index_reg <= palette_index_next;
      phase_reg <= phase_next;
      if (wr_end && color_acc && phase_reg == `CPL_PH_RED) begin
        red_hold_reg <= wr_data_reg; // (R5)
      end
      if (wr_end && color_acc && phase_reg == `CPL_PH_GRN) begin
        grn_hold_reg <= wr_data_reg; // (R5)
      end
    end
  end

  // palette storage has no reset; contents undefined until loaded
  always @(posedge clk_sys) begin
    if (pal_store) begin
      pal_mem[palette_index_reg] <= store_word; // (R5)
    end
  end

  // read data register: index for address target, else byte chosen by phase
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_reg <= 8'h00;
    end else if (sel_addr) begin
      rd_data_reg <= palette_index_reg;
    end else if (phase_reg == `CPL_PH_RED) begin
      rd_data_reg <= host_word[23:16]; // (R6)
    end else if (phase_reg == `CPL_PH_GRN) begin
      rd_data_reg <= host_word[15:8]; // (R6)
    end else begin
      rd_data_reg <= host_word[7:0]; // (R6)
    end
  end
  assign host_data_out = rd_data_reg;
  assign host_data_oe_n = !(rd_act && rd_act_reg);

  // pixel path, stage 1: capture inputs
  reg [7:0] pix_s1_reg;
  reg [1:0] ovl_s1_reg;
  reg sync_s1_reg;
  reg blank_s1_reg;
  reg black_s1_reg;
  reg [23:0] color_s2_reg;
  reg sync_s2_reg;
  reg blank_s2_reg;
  wire [23:0] pix_ovl_word;
  wire [23:0] pix_pal_word = pal_mem[pix_s1_reg];

  cpl_overlay_bank u_ovl (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(ovl_store),
    .wr_sel(palette_index_reg[1:0]), // (R8)
    .wr_data(store_word),
    .rd_sel_a(palette_index_reg[1:0]), // (R8)
    .rd_data_a(host_ovl_word),
    .rd_sel_b(ovl_s1_reg),
    .rd_data_b(pix_ovl_word)
  );

  // host port runs on its own strobes; no ordering against pixel flow
  always @(posedge clk_sys) begin // (R13)
    if (sys_rst) begin
      pix_s1_reg <= 8'h00;
      ovl_s1_reg <= 2'h0;
      sync_s1_reg <= 1'b1;
      blank_s1_reg <= 1'b1;
      black_s1_reg <= 1'b0;
      color_s2_reg <= 24'h000000;
      sync_s2_reg <= 1'b1;
      blank_s2_reg <= 1'b1;
    end else begin
      pix_s1_reg <= pixel_index;
      ovl_s1_reg <= {overlay_select_hi, overlay_select_lo};
      sync_s1_reg <= sync_n; // (R12)
      blank_s1_reg <= blank_n; // (R12)
      black_s1_reg <= !host_select_n;
      sync_s2_reg <= sync_s1_reg; // (R14)
      blank_s2_reg <= blank_s1_reg; // (R14)
      if (!blank_s1_reg || black_s1_reg) begin
        color_s2_reg <= {`CPL_BLACK, `CPL_BLACK, `CPL_BLACK}; // (R12)
      end else if (ovl_s1_reg == `CPL_OVL_RSVD) begin
        color_s2_reg <= pix_pal_word; // (R11)
      end else begin
        color_s2_reg <= pix_ovl_word; // (R11)
      end
    end
  end

  // select low forces black immediately, not after the pipe
  wire force_black = !host_select_n; // (R10)
  assign red_video_out = force_black ? `CPL_BLACK : color_s2_reg[23:16];
  assign green_video_out = force_black ? `CPL_BLACK : color_s2_reg[15:8];
  assign blue_video_out = force_black ? `CPL_BLACK : color_s2_reg[7:0];
  assign video_sync_n = sync_s2_reg; // (R12)
  assign video_blank_n = blank_s2_reg; // (R12)
endmodule // cpl_palette_lookup

// [tb/cpl_host_model.sv]
// host bus model driving the palette lookup host port
`timescale 1ns/10ps
module cpl_host_model (
  input wire clk_sys,
  output logic host_select_n,
  output logic host_read_n,
  output logic host_write_n,
  output logic target_select_lo,
  output logic target_select_hi,
  output logic [7:0] host_data_in
);
  initial begin
    {host_select_n, host_read_n, host_write_n} = 3'h7;
    {target_select_hi, target_select_lo} = 2'h0;
    host_data_in = 8'h00;
  end
  // two active cycles, then two idle cycles before the next access
  task acc(input logic wr, input logic [1:0] tgt, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {target_select_hi, target_select_lo} = tgt;
    host_data_in = d;
    host_select_n = 1'b0;
    if (wr) host_write_n = 1'b0; else host_read_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    {host_select_n, host_read_n, host_write_n} = 3'h7;
    host_data_in = ~d; // released bus must not show stale data
    @(posedge clk_sys);
  endtask
endmodule // cpl_host_model

// [tb/cpl_palette_lookup_assertions.sv]
// port checker for the color palette lookup block
`timescale 1ns/10ps
module cpl_chk (
  input logic clk_sys,
  input logic sys_rst,
  input logic host_select_n,
  input logic host_read_n,
  input logic host_write_n,
  input logic host_data_oe_n,
  input logic [7:0] red_video_out,
  input logic [7:0] green_video_out,
  input logic [7:0] blue_video_out,
  input logic sync_n,
  input logic blank_n,
  input logic video_sync_n,
  input logic video_blank_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_BLACK_R: assert property (!host_select_n |-> red_video_out == 8'h00)
    else $error("red not black while selected");
  AST_BLACK_G: assert property (!host_select_n |-> green_video_out == 8'h00)
    else $error("green not black while selected");
  AST_BLACK_B: assert property (!host_select_n |-> blue_video_out == 8'h00)
    else $error("blue not black while selected");
  AST_SYNC_PIPE: assert property (!$past(sys_rst, 2) |-> video_sync_n == $past(sync_n, 2))
    else $error("sync delay wrong");
  AST_BLANK_PIPE: assert property (!$past(sys_rst, 2) |-> video_blank_n == $past(blank_n, 2))
    else $error("blank delay wrong");
  AST_BLANK_COLOR: assert property (!video_blank_n |->
    (red_video_out | green_video_out | blue_video_out) == 8'h00)
    else $error("color while blanked");
  AST_OE_READ: assert property (!host_data_oe_n |-> !host_select_n && !host_read_n)
    else $error("bus driven outside read");
  AST_OE_LATE: assert property ((!host_select_n && !host_read_n && host_write_n)[*2]
    |-> !host_data_oe_n)
    else $error("read data not driven");
  cover property (!host_data_oe_n);
  cover property (host_select_n && !video_blank_n);
  cover property (!host_select_n && !host_write_n);
endmodule // cpl_chk
bind cpl_palette_lookup cpl_chk i_cpl_chk (.clk_sys, .sys_rst, .host_select_n, .host_read_n,
  .host_write_n, .host_data_oe_n, .red_video_out, .green_video_out, .blue_video_out, .sync_n,
  .blank_n, .video_sync_n, .video_blank_n);

// [tb/test_cpl_palette_lookup.sv]
// self-checking bench for the color palette lookup block
`timescale 1ns/10ps
`include "cpl_consts.vh"
`define CPL_CMP(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module test_cpl_palette_lookup;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  wire sel_n, rd_n, wr_n, tlo, thi, oe_n;
  wire [7:0] hdi, hdo, vr, vg, vb;
  logic [7:0] pix = 8'h00, e;
  logic [1:0] ovl = 2'h0;
  logic sync_n = 1'b1, blank_n = 1'b1, oe_d = 1'b1;
  integer mismatches = 0, total_checks = 0, seed = 32'hef25e6dd, i;
  logic [23:0] col [0:3];
  logic [7:0] exp_q [$];
  always #12.5 clk_sys = ~clk_sys;
  cpl_host_model i_cpl_host_model (.clk_sys(clk_sys), .host_select_n(sel_n), .host_read_n(rd_n),
    .host_write_n(wr_n), .target_select_lo(tlo), .target_select_hi(thi), .host_data_in(hdi));
  cpl_palette_lookup i_cpl_palette_lookup (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .host_select_n(sel_n), .host_read_n(rd_n), .host_write_n(wr_n), .target_select_lo(tlo),
    .target_select_hi(thi), .host_data_in(hdi), .host_data_out(hdo), .host_data_oe_n(oe_n),
    .pixel_index(pix), .overlay_select_lo(ovl[0]), .overlay_select_hi(ovl[1]), .sync_n(sync_n),
    .blank_n(blank_n), .red_video_out(vr), .green_video_out(vg), .blue_video_out(vb),
    .video_sync_n(), .video_blank_n());
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task hacc(input logic w, input logic [1:0] t, input logic [7:0] d, input logic [7:0] x);
    if (!w) exp_q.push_back(x);
    i_cpl_host_model.acc(w, t, d);
  endtask
  task xfer3(input logic w, input logic [1:0] t, input logic [23:0] c);
    for (int k = 2; k >= 0; k--) hacc(w, t, c[8*k +: 8], c[8*k +: 8]);
  endtask
  task pix_chk(input logic [7:0] p, input logic [1:0] o, input logic [23:0] c);
    @(posedge clk_sys);
    #1;
    {pix, ovl, sync_n, blank_n} = {p, o, 2'h3};
    repeat (3) @(posedge clk_sys);
    #1;
    `CPL_CMP({vr, vg, vb}, c)
  endtask
  // first read cycle is not valid yet, so compare on the falling edge of oe
  always @(negedge clk_sys) begin
    if (oe_n === 1'b0 && oe_d === 1'b1) begin
      e = exp_q.pop_front();
      `CPL_CMP(hdo, e)
    end
    oe_d <= oe_n;
  end
  initial begin
    #1000000;
    mismatches++;
    give_verdict;
  end
  initial begin
    for (i = 0; i < 4; i++) col[i] = 24'($random(seed));
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    hacc(1'b1, `CPL_TGT_ADDR_B, 8'hfe, 8'h00);
    for (i = 0; i < 3; i++) xfer3(1'b1, `CPL_TGT_PAL, col[i]);
    hacc(1'b0, `CPL_TGT_ADDR_A, 8'h00, 8'h01);
    hacc(1'b1, `CPL_TGT_ADDR_A, 8'hfe, 8'h00);
    hacc(1'b0, `CPL_TGT_PAL, 8'h00, col[0][23:16]);
    hacc(1'b0, `CPL_TGT_ADDR_B, 8'h00, 8'hfe);
    hacc(1'b0, `CPL_TGT_PAL, 8'h00, col[0][15:8]);
    hacc(1'b0, `CPL_TGT_PAL, 8'h00, col[0][7:0]);
    for (i = 1; i < 3; i++) xfer3(1'b0, `CPL_TGT_PAL, col[i]);
    hacc(1'b1, `CPL_TGT_ADDR_A, 8'hfd, 8'h00);
    xfer3(1'b1, `CPL_TGT_OVL, col[3]);
    hacc(1'b0, `CPL_TGT_ADDR_A, 8'h00, 8'hfe);
    hacc(1'b1, `CPL_TGT_ADDR_A, 8'h01, 8'h00);
    xfer3(1'b0, `CPL_TGT_OVL, col[3]);
    pix_chk(8'hfe, 2'h0, col[0]);
    pix_chk(8'h00, 2'h0, col[2]);
    pix_chk(8'h55, 2'h1, col[3]);
    // random pixel traffic exercises the sync and blank pipeline
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      #1;
      {pix, ovl, sync_n, blank_n} = 12'($random(seed));
    end
    `CPL_CMP(exp_q.size(), 0)
    give_verdict;
  end
endmodule // test_cpl_palette_lookup
